//--- inc/timer_capture_interrupt_unit_defines.vh
/*
  Constants of the timer, capture and interrupt unit: register offsets,
  field positions, interrupt source numbers and timing counts.
  Assumes a core clock of 250 MHz and an 8-bit register address.
*/
`ifndef TIMER_CAPTURE_INTERRUPT_UNIT_DEFINES_VH
`define TIMER_CAPTURE_INTERRUPT_UNIT_DEFINES_VH

// Clock and time base
`define CLK_PERIOD_NS   4
`define US_TICK_NS      1000
`define US_DIV_CYC      (`US_TICK_NS / `CLK_PERIOD_NS)
`define WDOG_TIME_MS    8
`define WDOG_US_CNT     (`WDOG_TIME_MS * 1000)
`define WAKE_US_CNT     1024

// Register offsets
`define REG_IRQ_STATUS  8'h00
`define REG_IRQ_MASK    8'h01
`define REG_IRQ_CTRL    8'h02
`define REG_TIMER       8'h03
`define REG_PIN_MASK    8'h04
`define REG_PIN_RISE    8'h05
`define REG_CAP_CTRL    8'h06
`define REG_CAP_A_RISE  8'h07
`define REG_CAP_A_FALL  8'h08
`define REG_CAP_B_RISE  8'h09
`define REG_CAP_B_FALL  8'h0A
`define REG_WDOG_CLR    8'h0B
`define REG_STACK_PTR   8'h0C
`define REG_VECTOR      8'h0D

// Field positions
`define CTRL_GIE_BIT    0
`define CAP_PS_LSB      0
`define CAP_PS_MSB      2
`define CAP_A_RISE_BIT  3
`define CAP_A_FALL_BIT  4
`define CAP_B_RISE_BIT  5
`define CAP_B_FALL_BIT  6

// Interrupt sources, index 0 has the highest priority
`define SRC_USB_RESET   0
`define SRC_T128        1
`define SRC_T1024       2
`define SRC_EP0         3
`define SRC_EP1         4
`define SRC_EP2         5
`define SRC_CAP_A       6
`define SRC_CAP_B       7
`define SRC_WAKE        8
`define SRC_PIN         9
`define NUM_SRC         10

`endif

//--- hdl/timer_capture_interrupt_unit.v
/*
  Timer, capture and vectored interrupt unit with watchdog and suspend
  wake-up timer. Registers sit on a plain strobe port with read data one
  cycle after the read strobe. Assumes all inputs synchronous to
  core_clk_in and an 8-bit core that pushes its state through the stack
  write port driven here.
*/
`include "timer_capture_interrupt_unit_defines.vh"

module timer_capture_interrupt_unit #(
  parameter PIN_W   = 16,
  parameter WDOG_US = `WDOG_US_CNT,
  parameter WAKE_US = `WAKE_US_CNT
) (
  input  wire              core_clk_in,
  input  wire              srst_in,
  input  wire [7:0]        reg_addr_in,
  input  wire [15:0]       reg_wdata_in,
  input  wire              reg_wr_in,
  input  wire              reg_rd_in,
  output wire [15:0]       reg_rdata_out,
  input  wire              usb_bus_reset_in,
  input  wire [2:0]        ep_done_in,
  input  wire              capture_input_a_in,
  input  wire              capture_input_b_in,
  input  wire [PIN_W-1:0]  pin_in,
  input  wire              suspend_in,
  input  wire              int_ack_in,
  input  wire [13:0]       ret_pc_in,
  input  wire              ret_carry_in,
  input  wire              ret_zero_in,
  output wire              irq_out,
  output wire              int_enable_out,
  output wire [3:0]        int_vector_out,
  output wire              stack_we_out,
  output wire [7:0]        stack_addr_out,
  output wire [7:0]        stack_data_out,
  output wire              watchdog_reset_event_out
);

  localparam integer US_DIV   = `US_DIV_CYC;
  localparam [7:0]  US_LAST   = US_DIV[7:0] - 8'h01;
  localparam [12:0] WDOG_LAST = WDOG_US[12:0] - 13'h0001;
  localparam [15:0] WAKE_LAST = WAKE_US[15:0] - 16'h0001;
  localparam        ST_IDLE   = 1'b0;
  localparam        ST_PUSH_HI = 1'b1;

  // Register state
  reg [7:0]        us_div_q;
  reg              us_tick_q;
  reg [11:0]       timer_q;
  reg [9:0]        status_q;
  reg [9:0]        mask_q;
  reg              gie_q;
  reg [PIN_W-1:0]  pin_mask_q;
  reg [PIN_W-1:0]  pin_rise_q;
  reg [PIN_W-1:0]  pin_prev_q;
  reg [6:0]        cap_ctrl_q;
  reg [7:0]        cap_a_rise_q;
  reg [7:0]        cap_a_fall_q;
  reg [7:0]        cap_b_rise_q;
  reg [7:0]        cap_b_fall_q;
  reg              cap_a_prev_q;
  reg              cap_b_prev_q;
  reg [12:0]       wdog_cnt_q;
  reg              wdog_fire_q;
  reg [15:0]       wake_cnt_q;
  reg [7:0]        psp_q;
  reg              st_q;
  reg              stack_we_q;
  reg [7:0]        stack_addr_q;
  reg [7:0]        stack_data_q;
  reg [7:0]        push_hi_q;
  reg [3:0]        vector_q;
  reg [15:0]       rdata_q;

  // Combinational terms
  wire             rst;
  wire             wr_hit_status;
  wire [9:0]       events;
  wire [9:0]       active;
  wire [PIN_W-1:0] pin_rise_ev;
  wire [PIN_W-1:0] pin_fall_ev;
  wire             pin_ev;
  wire             a_rise_st;
  wire             a_fall_st;
  wire             b_rise_st;
  wire             b_fall_st;
  wire             wake_ev;
  wire             ack_take;
  reg  [7:0]       cap_slice;
  reg  [3:0]       prio_idx;
  reg  [15:0]      rd_mux;
  integer          i;

  // Watchdog expiry resets the unit like an external reset
  // watchdog forces reset
  assign rst = srst_in | wdog_fire_q;

  // 1 MHz tick from the core clock
  always @(posedge core_clk_in) begin
    if (rst) begin
      us_div_q  <= 8'h00;
      us_tick_q <= 1'b0;
    end else begin
      us_tick_q <= (us_div_q == US_LAST);
      us_div_q  <= (us_div_q == US_LAST) ? 8'h00 : us_div_q + 8'h01;
    end
  end

  // Free-running counter, wraps silently; firmware subtracts readings
  // counter advance
  always @(posedge core_clk_in) begin
    if (rst) begin
      timer_q <= 12'h000;
    end else if (us_tick_q) begin
      timer_q <= timer_q + 12'h001;
    end
  end

  // Pin edge detection against last sample
  // per-pin edge polarity
  assign pin_rise_ev = pin_in & ~pin_prev_q & pin_rise_q;
  assign pin_fall_ev = ~pin_in & pin_prev_q & ~pin_rise_q;
  assign pin_ev = |((pin_rise_ev | pin_fall_ev) & pin_mask_q);

  always @(posedge core_clk_in) begin
    if (rst) begin
      pin_prev_q   <= {PIN_W{1'b0}};
      cap_a_prev_q <= 1'b0;
      cap_b_prev_q <= 1'b0;
    end else begin
      pin_prev_q   <= pin_in;
      cap_a_prev_q <= capture_input_a_in;
      cap_b_prev_q <= capture_input_b_in;
    end
  end

  // Prescaler picks which 8 bits of the counter are captured;
  // codes above the last setting fall back to the coarsest slice
  // five prescaler settings
  always @* begin
    case (cap_ctrl_q[`CAP_PS_MSB:`CAP_PS_LSB])
      3'h0: cap_slice = timer_q[7:0];
      3'h1: cap_slice = timer_q[8:1];
      3'h2: cap_slice = timer_q[9:2];
      3'h3: cap_slice = timer_q[10:3];
      default: cap_slice = timer_q[11:4];
    endcase
  end

  // Capture edges, each edge kind enabled separately
  assign a_rise_st = capture_input_a_in & ~cap_a_prev_q & cap_ctrl_q[`CAP_A_RISE_BIT];
  assign a_fall_st = ~capture_input_a_in & cap_a_prev_q & cap_ctrl_q[`CAP_A_FALL_BIT];
  assign b_rise_st = capture_input_b_in & ~cap_b_prev_q & cap_ctrl_q[`CAP_B_RISE_BIT];
  assign b_fall_st = ~capture_input_b_in & cap_b_prev_q & cap_ctrl_q[`CAP_B_FALL_BIT];

  // Four capture registers, one per pin and edge
  // store counter slice
  always @(posedge core_clk_in) begin
    if (rst) begin
      cap_a_rise_q <= 8'h00;
      cap_a_fall_q <= 8'h00;
      cap_b_rise_q <= 8'h00;
      cap_b_fall_q <= 8'h00;
    end else begin
      if (a_rise_st) begin
        cap_a_rise_q <= cap_slice;
      end
      if (a_fall_st) begin
        cap_a_fall_q <= cap_slice;
      end
      if (b_rise_st) begin
        cap_b_rise_q <= cap_slice;
      end
      if (b_fall_st) begin
        cap_b_fall_q <= cap_slice;
      end
    end
  end

  // Wake-up timer only runs in suspend; restarts on each entry
  // suspend wake-up requests
  assign wake_ev = suspend_in & us_tick_q & (wake_cnt_q == WAKE_LAST);

  always @(posedge core_clk_in) begin
    if (rst || !suspend_in) begin
      wake_cnt_q <= 16'h0000;
    end else if (us_tick_q) begin
      wake_cnt_q <= (wake_cnt_q == WAKE_LAST) ? 16'h0000 : wake_cnt_q + 16'h0001;
    end
  end

  // Watchdog counts microseconds until firmware writes the clear
  // register; its fire flop drops by itself after one cycle and is reset only by the external reset
  // watchdog timeout
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      wdog_fire_q <= 1'b0;
    end else begin
      wdog_fire_q <= ~wdog_fire_q & us_tick_q & (wdog_cnt_q == WDOG_LAST);
    end
  end

  always @(posedge core_clk_in) begin
    if (rst) begin
      wdog_cnt_q <= 13'h0000;
    end else if (reg_wr_in && reg_addr_in == `REG_WDOG_CLR) begin
      wdog_cnt_q <= 13'h0000;
    end else if (us_tick_q && wdog_cnt_q != WDOG_LAST) begin
      wdog_cnt_q <= wdog_cnt_q + 13'h0001;
    end
  end

  // Event vector, one bit per source
  // source set
  assign events[`SRC_USB_RESET] = usb_bus_reset_in;
  assign events[`SRC_T128]      = us_tick_q & (timer_q[6:0] == 7'h7F);
  assign events[`SRC_T1024]     = us_tick_q & (timer_q[9:0] == 10'h3FF);
  assign events[`SRC_EP0]       = ep_done_in[0];
  assign events[`SRC_EP1]       = ep_done_in[1];
  assign events[`SRC_EP2]       = ep_done_in[2];
  assign events[`SRC_CAP_A]     = a_rise_st | a_fall_st;
  assign events[`SRC_CAP_B]     = b_rise_st | b_fall_st;
  assign events[`SRC_WAKE]      = wake_ev;
  assign events[`SRC_PIN]       = pin_ev;

  // Enabled pending sources; timer ticks gated by their mask bits
  // tick enable gate
  assign active  = status_q & mask_q;
  assign irq_out = |active;
  assign int_enable_out = gie_q;

  // Lowest index wins among active sources
  // fixed priority select
  always @* begin
    prio_idx = 4'h0;
    for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
      if (active[i]) begin
        prio_idx = i[3:0];
      end
    end
  end

  // Acknowledge is ignored when nothing is eligible or a push runs
  assign ack_take = int_ack_in & gie_q & irq_out & (st_q == ST_IDLE);
  assign wr_hit_status = reg_wr_in && reg_addr_in == `REG_IRQ_STATUS;

  // Sticky status: a new event beats a write-one clear
  // clear on acknowledge
  always @(posedge core_clk_in) begin
    if (rst) begin
      status_q <= 10'h000;
    end else begin
      status_q <= (status_q
                   & ~(wr_hit_status ? reg_wdata_in[9:0] : 10'h000)
                   & ~(ack_take ? (10'h001 << prio_idx) : 10'h000))
                  | events;
    end
  end

  // Software configuration registers
  always @(posedge core_clk_in) begin
    if (rst) begin
      mask_q     <= 10'h000;
      pin_mask_q <= {PIN_W{1'b0}};
      pin_rise_q <= {PIN_W{1'b0}};
      cap_ctrl_q <= 7'h00;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `REG_IRQ_MASK: mask_q     <= reg_wdata_in[9:0];
        `REG_PIN_MASK: pin_mask_q <= reg_wdata_in[PIN_W-1:0];
        `REG_PIN_RISE: pin_rise_q <= reg_wdata_in[PIN_W-1:0];
        `REG_CAP_CTRL: cap_ctrl_q <= reg_wdata_in[6:0];
        default: ;
      endcase
    end
  end

  // Acknowledge sequence: disable, latch vector, push two bytes;
  // acknowledge wins over a same-cycle software write
  // disable and push
  always @(posedge core_clk_in) begin
    if (rst) begin
      gie_q        <= 1'b0;
      psp_q        <= 8'h00;
      st_q         <= ST_IDLE;
      stack_we_q   <= 1'b0;
      stack_addr_q <= 8'h00;
      stack_data_q <= 8'h00;
      push_hi_q    <= 8'h00;
      vector_q     <= 4'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (ack_take) begin
            gie_q        <= 1'b0;
            vector_q     <= prio_idx;
            stack_we_q   <= 1'b1;
            stack_addr_q <= psp_q;
            stack_data_q <= ret_pc_in[7:0];
            push_hi_q    <= {ret_carry_in, ret_zero_in, ret_pc_in[13:8]};
            psp_q        <= psp_q + 8'h01;
            st_q         <= ST_PUSH_HI;
          end else begin
            stack_we_q <= 1'b0;
            if (reg_wr_in && reg_addr_in == `REG_IRQ_CTRL) begin
              gie_q <= reg_wdata_in[`CTRL_GIE_BIT];
            end
            if (reg_wr_in && reg_addr_in == `REG_STACK_PTR) begin
              psp_q <= reg_wdata_in[7:0];
            end
          end
        end
        ST_PUSH_HI: begin
          stack_we_q   <= 1'b1;
          stack_addr_q <= psp_q;
          stack_data_q <= push_hi_q;
          psp_q        <= psp_q + 8'h01;
          st_q         <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign int_vector_out = vector_q;
  assign stack_we_out   = stack_we_q;
  assign stack_addr_out = stack_addr_q;
  assign stack_data_out = stack_data_q;
  assign watchdog_reset_event_out = wdog_fire_q;

  // Read mux; unmapped offsets read zero
  // counter readable
  always @* begin
    rd_mux = 16'h0000;
    case (reg_addr_in)
      `REG_IRQ_STATUS: rd_mux = {6'h00, status_q};
      `REG_IRQ_MASK:   rd_mux = {6'h00, mask_q};
      `REG_IRQ_CTRL:   rd_mux = {15'h0000, gie_q};
      `REG_TIMER:      rd_mux = {4'h0, timer_q};
      `REG_PIN_MASK:   rd_mux[PIN_W-1:0] = pin_mask_q;
      `REG_PIN_RISE:   rd_mux[PIN_W-1:0] = pin_rise_q;
      `REG_CAP_CTRL:   rd_mux = {9'h000, cap_ctrl_q};
      `REG_CAP_A_RISE: rd_mux = {8'h00, cap_a_rise_q};
      `REG_CAP_A_FALL: rd_mux = {8'h00, cap_a_fall_q};
      `REG_CAP_B_RISE: rd_mux = {8'h00, cap_b_rise_q};
      `REG_CAP_B_FALL: rd_mux = {8'h00, cap_b_fall_q};
      `REG_STACK_PTR:  rd_mux = {8'h00, psp_q};
      `REG_VECTOR:     rd_mux = {12'h000, vector_q};
      default:         rd_mux = 16'h0000;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge core_clk_in) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd_in ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata_out = rdata_q;

endmodule

//--- bench/timer_capture_interrupt_unit_chk.sv
/* Port checker for the timer, capture and interrupt unit.
   Assumes one clock and a synchronous active-high reset. */
module timer_capture_interrupt_unit_chk (
  input wire logic        core_clk_in,
  input wire logic        srst_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        int_ack_in,
  input wire logic [13:0] ret_pc_in,
  input wire logic        ret_carry_in,
  input wire logic        ret_zero_in,
  input wire logic        irq_out,
  input wire logic        int_enable_out,
  input wire logic [3:0]  int_vector_out,
  input wire logic        stack_we_out,
  input wire logic [7:0]  stack_addr_out,
  input wire logic [7:0]  stack_data_out,
  input wire logic        watchdog_reset_event_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lo_byte;
  logic [7:0] hi_byte;
  // Bytes the core offers for the push
  assign lo_byte = ret_pc_in[7:0];
  assign hi_byte = {ret_carry_in, ret_zero_in, ret_pc_in[13:8]};
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  // Acknowledge that the unit must take
  sequence taken;
    int_ack_in && int_enable_out && irq_out && !stack_we_out;
  endsequence
  a_rdata_slot: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000) else $error("stray read data");
  a_ack_push: assert property (
    taken |=> stack_we_out && !int_enable_out ##1 stack_we_out ##1 !stack_we_out)
    else $error("ack push sequence wrong");
  a_push_bytes: assert property (
    taken |=> stack_data_out == $past(lo_byte) ##1 stack_data_out == $past(hi_byte, 2))
    else $error("pushed bytes wrong");
  a_push_addr: assert property (
    $rose(stack_we_out) |=> stack_addr_out == $past(stack_addr_out) + 8'h01)
    else $error("second push address wrong");
  a_we_pair: assert property (
    $rose(stack_we_out) |-> stack_we_out [*2] ##1 !stack_we_out) else $error("push length");
  a_vector_hold: assert property (
    $changed(int_vector_out) |-> $rose(stack_we_out) || $past(watchdog_reset_event_out))
    else $error("vector moved without ack");
  a_ack_refused: assert property (
    int_ack_in && !(int_enable_out && irq_out) && !stack_we_out |=> !stack_we_out)
    else $error("refused ack pushed");
  a_wdog_pulse: assert property (
    watchdog_reset_event_out |=> !watchdog_reset_event_out) else $error("wdog pulse long");
  a_wdog_clear: assert property (
    watchdog_reset_event_out |=> !int_enable_out && !stack_we_out)
    else $error("wdog left state");
  c_taken: cover property (taken);
  c_wdog: cover property (watchdog_reset_event_out);
  c_irq: cover property ($rose(irq_out));
endmodule

bind timer_capture_interrupt_unit timer_capture_interrupt_unit_chk
  timer_capture_interrupt_unit_chk_i (
  .core_clk_in(core_clk_in), .srst_in(srst_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .int_ack_in(int_ack_in), .ret_pc_in(ret_pc_in),
  .ret_carry_in(ret_carry_in), .ret_zero_in(ret_zero_in), .irq_out(irq_out),
  .int_enable_out(int_enable_out), .int_vector_out(int_vector_out),
  .stack_we_out(stack_we_out), .stack_addr_out(stack_addr_out),
  .stack_data_out(stack_data_out), .watchdog_reset_event_out(watchdog_reset_event_out));

//--- bench/cpu_core_model.sv
/* Stand-in for the processor core: acks requests after a delay and
   keeps pushed bytes. Assumes the unit's clock and sync reset. */
module cpu_core_model (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       irq_in,
  input  wire logic       ien_in,
  input  wire logic       rude_in,
  input  wire logic       we_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] data_in,
  input  wire logic [7:0] delay_in,
  output logic            ack_out,
  output logic [13:0]     pc_out,
  output logic            carry_out,
  output logic            zero_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] wait_q;
  always @(posedge clk_in) begin
    if (we_in)
      mem[addr_in] <= data_in;
  end
  // vectored request acked; rude mode ignores the enable on purpose
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    if (srst_in) begin
      wait_q    <= 8'h00;
      pc_out    <= 14'h2A5C;
      carry_out <= 1'b1;
      zero_out  <= 1'b0;
    end else if (ack_out && ien_in) begin
      wait_q    <= 8'h00;
      pc_out    <= pc_out + 14'h0001;
      carry_out <= ~carry_out;
    end else if (irq_in && (ien_in || rude_in) && !we_in && !ack_out) begin
      if (wait_q >= delay_in)
        ack_out <= 1'b1;
      else
        wait_q <= wait_q + 8'h01;
    end else if (!irq_in) begin
      wait_q <= 8'h00;
    end
  end
endmodule

//--- bench/timer_capture_interrupt_unit_tb_top.sv
/* Self-checking bench for the timer, capture and interrupt unit.
   Assumes the core stand-in and the bound port checker. */
`include "timer_capture_interrupt_unit_defines.vh"
`define CHK(g, e) chk(32'(g), 32'(e))
module timer_capture_interrupt_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        usb_rst = 1'b0;
  logic [2:0]  ep_done = 3'h0;
  logic        cap_a = 1'b0;
  logic        cap_b = 1'b0;
  logic [15:0] pins = 16'h0000;
  logic        suspend = 1'b0;
  logic        rude = 1'b0;
  logic [7:0]  delay = 8'h00;
  logic [7:0]  exp_stk [4] = '{8'h5C, 8'hAA, 8'h5D, 8'h2A};
  wire  [15:0] rdata;
  wire  [13:0] pc;
  wire  [3:0]  vec;
  wire  [7:0]  saddr, sdata;
  wire         ack, carry, zero, irq, ien, swe, watchdog_reset_event;
  logic        irq_seen, ien_seen;
  logic [15:0] d, t0;
  int          n_mismatch = 0, n_compared = 0, cyc = 0, n;

  timer_capture_interrupt_unit #(.PIN_W(16), .WDOG_US(40), .WAKE_US(4))
    timer_capture_interrupt_unit_i (
    .core_clk_in(clk), .srst_in(srst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .usb_bus_reset_in(usb_rst),
    .ep_done_in(ep_done), .capture_input_a_in(cap_a), .capture_input_b_in(cap_b),
    .pin_in(pins), .suspend_in(suspend), .int_ack_in(ack), .ret_pc_in(pc),
    .ret_carry_in(carry), .ret_zero_in(zero), .irq_out(irq), .int_enable_out(ien),
    .int_vector_out(vec), .stack_we_out(swe), .stack_addr_out(saddr),
    .stack_data_out(sdata), .watchdog_reset_event_out(watchdog_reset_event));
  cpu_core_model cpu_core_model_i (
    .clk_in(clk), .srst_in(srst), .irq_in(irq), .ien_in(ien), .rude_in(rude),
    .we_in(swe), .addr_in(saddr), .data_in(sdata), .delay_in(delay), .ack_out(ack),
    .pc_out(pc), .carry_out(carry), .zero_out(zero));

  // 250 MHz clock
  initial forever #2 clk = ~clk;
  // Settled copies of level outputs, away from the edge
  always @(negedge clk) begin
    irq_seen = irq;
    ien_seen = ien;
  end
  // Cut a hang short; the tests need about 50k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle cycle after each write keeps strobe edges apart
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  // Long wait that keeps the watchdog serviced
  task automatic idle(input int cnt);
    for (int i = 0; i < cnt; i += 400) begin
      wr_reg(`REG_WDOG_CLR, 16'h0000);
      repeat (398) @(posedge clk);
    end
  endtask
  task automatic stat_is(input logic [15:0] e);
    rd_reg(`REG_IRQ_STATUS, d);
    `CHK(d, e);
    wr_reg(`REG_IRQ_STATUS, d);
  endtask
  task automatic pin_step(input logic [15:0] v, input logic [15:0] e);
    pins <= v;
    repeat (3) @(posedge clk);
    stat_is(e);
  endtask
  function automatic logic [7:0] sl(input logic [15:0] t, input int ps);
    return 8'(t >> (ps < 4 ? ps : 4));
  endfunction
  task automatic print_verdict();
    $display("compared=%0d mismatched=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    stat_is(16'h0000);
    // Counter moves once per 250 clocks
    rd_reg(`REG_TIMER, t0);
    repeat (1248) @(posedge clk);
    rd_reg(`REG_TIMER, d);
    `CHK((d - t0) & 16'h0FFF, 5);
    // Each event sets its own bit; rude acks meanwhile must be refused
    wr_reg(`REG_IRQ_MASK, 16'h03FF);
    rude <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      if (s == 0)
        usb_rst <= 1'b1;
      else
        ep_done <= 3'(1 << (s - 1));
      @(posedge clk);
      usb_rst <= 1'b0;
      ep_done <= 3'h0;
      repeat (2) @(posedge clk);
      `CHK(irq_seen, 1'b1);
      stat_is(s == 0 ? 16'h0001 : 16'(4 << s));
    end
    rude <= 1'b0;
    // Pin 0 alone may interrupt, on the chosen edge only
    wr_reg(`REG_PIN_MASK, 16'h0001);
    wr_reg(`REG_PIN_RISE, 16'h0001);
    pin_step(16'h0002, 16'h0000);
    pin_step(16'h0003, 16'h0200);
    pin_step(16'h0002, 16'h0000);
    wr_reg(`REG_PIN_RISE, 16'h0000);
    pin_step(16'h0003, 16'h0000);
    pin_step(16'h0002, 16'h0200);
    // Both capture pins, every prescaler, both edges
    for (int ps = 0; ps < 5; ps++) begin
      wr_reg(`REG_CAP_CTRL, 16'(ps) | 16'h0078);
      for (int e = 0; e < 2; e++) begin
        rd_reg(`REG_TIMER, t0);
        cap_a <= ~cap_a;
        cap_b <= ~cap_b;
        repeat (3) @(posedge clk);
        rd_reg(`REG_CAP_A_RISE + 8'(e), d);
        `CHK(d == sl(t0, ps) || d == sl(t0 + 1, ps), 1);
        rd_reg(`REG_CAP_B_RISE + 8'(e), d);
        `CHK(d == sl(t0, ps) || d == sl(t0 + 1, ps), 1);
        stat_is(16'h00C0);
      end
    end
    // Two endpoints pending: lower index first, second ack answered late
    wr_reg(`REG_STACK_PTR, 16'h0010);
    ep_done <= 3'h5;
    @(posedge clk);
    ep_done <= 3'h0;
    for (int k = 0; k < 2; k++) begin
      delay <= k ? 8'h05 : 8'h00;
      wr_reg(`REG_IRQ_CTRL, 16'h0001);
      repeat (12) @(posedge clk);
      `CHK(vec, k ? 4'h5 : 4'h3);
      `CHK(ien_seen, 1'b0);
    end
    for (int i = 0; i < 4; i++)
      `CHK(cpu_core_model_i.mem[16 + i], exp_stk[i]);
    rd_reg(`REG_STACK_PTR, d);
    `CHK(d, 16'h0014);
    stat_is(16'h0000);
    // Wake-up only while suspended
    suspend <= 1'b1;
    idle(1100);
    suspend <= 1'b0;
    stat_is(16'h0100);
    idle(1100);
    stat_is(16'h0000);
    // Tick latches even while its request is masked
    wr_reg(`REG_IRQ_MASK, 16'h0000);
    idle(32500);
    rd_reg(`REG_IRQ_STATUS, d);
    `CHK(d, 16'h0002);
    `CHK(irq_seen, 1'b0);
    wr_reg(`REG_IRQ_MASK, 16'h0002);
    @(posedge clk);
    `CHK(irq_seen, 1'b1);
    // Unserviced watchdog fires near its period and clears state
    wr_reg(`REG_IRQ_STATUS, 16'h03FF);
    wr_reg(`REG_IRQ_CTRL, 16'h0001);
    wr_reg(`REG_WDOG_CLR, 16'h0000);
    n = 0;
    while (watchdog_reset_event !== 1'b1 && n < 11000) begin
      @(negedge clk);
      n++;
    end
    `CHK(n > 9700 && n < 10300, 1);
    repeat (2) @(posedge clk);
    rd_reg(`REG_IRQ_CTRL, d);
    `CHK(d, 16'h0000);
    rd_reg(`REG_IRQ_MASK, d);
    `CHK(d, 16'h0000);
    print_verdict();
  end
endmodule
